/* include/ofef_cfg.svh */
// Purpose: offsets, field positions, reset values and timing for the fault/event flag block
// Assumes: 8-bit registers on page 0 of the control bus
// Notes:   included by bare name
`ifndef OFEF_CFG_SVH
`define OFEF_CFG_SVH

`define OFEF_ADDR_W          7
`define OFEF_OFS_BTN_CLR     7'h0E
`define OFEF_OFS_SC_STATUS   7'h5F
`define OFEF_OFS_LATCHED     7'h60
`define OFEF_OFS_LIVE        7'h61
`define OFEF_OFS_PIN_CTRL    7'h62

`define OFEF_BIT_SC_LEFT     7
`define OFEF_BIT_SC_RIGHT    6
`define OFEF_BIT_SC_COMMON   5
`define OFEF_BIT_COM_PWR     3
`define OFEF_BIT_BUTTON      3
`define OFEF_BIT_HEADSET     2
`define OFEF_BIT_GATE_LEFT   1
`define OFEF_BIT_GATE_RIGHT  0
`define OFEF_BIT_REPEAT      2

`define OFEF_RST_REG         8'h00
`define OFEF_SC_STATUS_MASK  8'hE8
`define OFEF_FLAGS_MASK      8'hEF

`define OFEF_CLK_HZ          20000000
`define OFEF_PULSE_ON_US     1000
`define OFEF_PULSE_OFF_US    1000
`define OFEF_PULSE_ON_CYC    ((`OFEF_PULSE_ON_US * (`OFEF_CLK_HZ / 1000000)))
`define OFEF_PULSE_OFF_CYC   ((`OFEF_PULSE_OFF_US * (`OFEF_CLK_HZ / 1000000)))

`endif

/* include/ofef_pkg.sv */
// Purpose: types for the fault/event flag block
// Assumes: nothing
// Notes:   none
package ofef_pkg;

    typedef struct packed {
        logic sc_left;
        logic sc_right;
        logic sc_common;
        logic com_pwr;
        logic button;
        logic headset;
        logic gate_left;
        logic gate_right;
    } ofef_src_t;

    typedef enum logic [2:0] {
        PL_IDLE = 3'b001,
        PL_HIGH = 3'b010,
        PL_LOW  = 3'b100
    } ofef_pulse_t;

endpackage

/* src/ofef_sync.sv */
// Purpose: two-stage synchroniser bank for detector inputs
// Assumes: inputs are asynchronous to CLOCK
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module ofef_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,   // system clock
    input  wire logic             reset_n, // async reset, active low
    input  wire logic [WIDTH-1:0] d,       // asynchronous levels
    output logic      [WIDTH-1:0] q        // synchronised levels
);
    logic [WIDTH-1:0] stage1;

    // refuse an empty bank at elaboration
    if (WIDTH < 1)
    begin : g_bad_width
        $error("ofef_sync: WIDTH must be at least 1");
    end

    generate
        for (genvar i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    stage1[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end
                else
                begin
                    stage1[i] <= d[i];
                    q[i]      <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

/* src/ofef_flags.sv */
// Purpose: short-circuit/power status, latched and live event flags, host reads them
// Assumes: host read strobe is one cycle, on CLOCK; detector levels are asynchronous
// Notes:   read data registered one cycle after the strobe
// Contract
// RQ1: status bits 7,6,5 show live short circuit on left, right, common drivers.
// RQ2: status bit 3 reads one only when common driver is fully powered.
// RQ3: reserved status bits 4 and 2..0 read zero; host never writes them.
// RQ4: latched register bits 7,6,5 record short-circuit events per driver.
// RQ5: latched bit 2 sets on headset insertion or removal.
// RQ6: latched bit 3 sets on a headset button press.
// RQ7: bits 1 and 0 show left and right noise-gate condition in both flag registers.
// RQ8: live register mirrors the same sources at the same bit positions.
// RQ9: live bit 2 is one while a headset is present.
// RQ10: live button bit is sticky, cleared only by reading register 14.
// RQ11: in repeat mode the pin keeps pulsing until latched register is read.
// RQ12: latched bits hold until the host read; live bits other than the sticky button bit 3 follow detectors.
`timescale 1ns/1ns
`include "ofef_cfg.svh"
module ofef_flags #(
    parameter int PULSE_ON_CYC  = `OFEF_PULSE_ON_CYC,
    parameter int PULSE_OFF_CYC = `OFEF_PULSE_OFF_CYC
) (
    input  wire logic                    CLOCK,      // 20 MHz clock
    input  wire logic                    RESET_N,    // async reset, active low
    input  wire logic                    SC_LEFT,    // left headphone driver short
    input  wire logic                    SC_RIGHT,   // right headphone driver short
    input  wire logic                    SC_COMMON,  // common headphone driver short
    input  wire logic                    COM_PWR_UP, // common driver fully powered
    input  wire logic                    BUTTON,     // headset button held
    input  wire logic                    HEADSET,    // headset present
    input  wire logic                    GATE_LEFT,  // left noise gate active
    input  wire logic                    GATE_RIGHT, // right noise gate active
    input  wire logic                    RD_STB,     // host read strobe
    input  wire logic                    WR_STB,     // host write strobe
    input  wire logic [`OFEF_ADDR_W-1:0] ADDR,       // register offset
    input  wire logic [7:0]              WDATA,      // write data
    output logic      [7:0]              RDATA,      // read data
    output logic                         RVALID,     // read data valid pulse
    output logic                         PIN_IRQ     // general_pin_one repeat pulse
);
    ofef_pkg::ofef_src_t src;
    ofef_pkg::ofef_src_t src_d;
    ofef_pkg::ofef_pulse_t pstate;
    logic [7:0]  latched;
    logic [7:0]  live;
    logic [7:0]  sc_status;
    logic [7:0]  next_latched;
    logic [7:0]  set_ev;
    logic        button_sticky;
    logic        repeat_en;
    logic        rd_latched;
    logic        rd_btn_clr;
    logic [31:0] pcount;

    // zero-length phases cannot be counted, refused at elaboration
    if (PULSE_ON_CYC < 1 || PULSE_OFF_CYC < 1)
    begin : g_bad_pulse
        $error("ofef_flags: pulse counts must be at least one");
    end

    function automatic logic hit(input logic [`OFEF_ADDR_W-1:0] a,
                                 input logic [`OFEF_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    ofef_sync #(
        .WIDTH (8)
    ) u_sync (
        .clock   (CLOCK),
        .reset_n (RESET_N),
        .d       ({SC_LEFT, SC_RIGHT, SC_COMMON, COM_PWR_UP,
                   BUTTON, HEADSET, GATE_LEFT, GATE_RIGHT}),
        .q       (src)
    );

    assign rd_latched = RD_STB && hit(ADDR, `OFEF_OFS_LATCHED);
    assign rd_btn_clr = RD_STB && hit(ADDR, `OFEF_OFS_BTN_CLR);

    // previous levels for edge detection
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            src_d <= '0;
        else
            src_d <= src;
    end

    always_comb
    begin
        set_ev = 8'h00;
        set_ev[`OFEF_BIT_SC_LEFT]    = src.sc_left;    // RQ4
        set_ev[`OFEF_BIT_SC_RIGHT]   = src.sc_right;   // RQ4
        set_ev[`OFEF_BIT_SC_COMMON]  = src.sc_common;  // RQ4
        set_ev[`OFEF_BIT_BUTTON]     = src.button & ~src_d.button; // RQ6
        set_ev[`OFEF_BIT_HEADSET]    = src.headset ^ src_d.headset; // RQ5
        set_ev[`OFEF_BIT_GATE_LEFT]  = src.gate_left;  // RQ7
        set_ev[`OFEF_BIT_GATE_RIGHT] = src.gate_right; // RQ7
        // set wins over the clearing read
        next_latched = ((rd_latched ? 8'h00 : latched) | set_ev) & `OFEF_FLAGS_MASK; // RQ12
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            latched <= `OFEF_RST_REG;
        else
            latched <= next_latched; // RQ12
    end

    // live button bit is sticky until register 14 is read
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            button_sticky <= 1'b0;
        else if (set_ev[`OFEF_BIT_BUTTON])
            button_sticky <= 1'b1; // RQ10
        else if (rd_btn_clr)
            button_sticky <= 1'b0; // RQ10
    end

    always_comb
    begin
        live = 8'h00;
        live[`OFEF_BIT_SC_LEFT]    = src.sc_left;    // RQ8
        live[`OFEF_BIT_SC_RIGHT]   = src.sc_right;   // RQ8
        live[`OFEF_BIT_SC_COMMON]  = src.sc_common;  // RQ8
        live[`OFEF_BIT_BUTTON]     = button_sticky;  // RQ10
        live[`OFEF_BIT_HEADSET]    = src.headset;    // RQ9
        live[`OFEF_BIT_GATE_LEFT]  = src.gate_left;  // RQ7
        live[`OFEF_BIT_GATE_RIGHT] = src.gate_right; // RQ7
        sc_status = 8'h00;                           // RQ3
        sc_status[`OFEF_BIT_SC_LEFT]   = src.sc_left;   // RQ1
        sc_status[`OFEF_BIT_SC_RIGHT]  = src.sc_right;  // RQ1
        sc_status[`OFEF_BIT_SC_COMMON] = src.sc_common; // RQ1
        sc_status[`OFEF_BIT_COM_PWR]   = src.com_pwr;   // RQ2
    end

    // pin control: only the repeat-duration bit is held here
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
            repeat_en <= 1'b0;
        else if (WR_STB && hit(ADDR, `OFEF_OFS_PIN_CTRL))
            repeat_en <= WDATA[`OFEF_BIT_REPEAT];
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            RDATA  <= `OFEF_RST_REG;
            RVALID <= 1'b0;
        end
        else
        begin
            RVALID <= RD_STB;
            if (!RD_STB)
                RDATA <= 8'h00;
            else if (hit(ADDR, `OFEF_OFS_SC_STATUS))
                RDATA <= sc_status & `OFEF_SC_STATUS_MASK; // RQ3
            else if (hit(ADDR, `OFEF_OFS_LATCHED))
                RDATA <= latched;
            else if (hit(ADDR, `OFEF_OFS_LIVE))
                RDATA <= live & `OFEF_FLAGS_MASK;
            else if (hit(ADDR, `OFEF_OFS_PIN_CTRL))
                RDATA <= {5'b0_0000, repeat_en, 2'b00};
            else
                RDATA <= 8'h00;
        end
    end

    // repeated pulses while any latched flag stands, stopped by its read
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pstate  <= ofef_pkg::PL_IDLE;
            pcount  <= 32'h0000_0000;
            PIN_IRQ <= 1'b0;
        end
        else if (!repeat_en || rd_latched || latched == 8'h00)
        begin
            pstate  <= ofef_pkg::PL_IDLE; // RQ11
            pcount  <= 32'h0000_0000;
            PIN_IRQ <= 1'b0;
        end
        else
        begin
            case (pstate)
                ofef_pkg::PL_IDLE:
                begin
                    pstate  <= ofef_pkg::PL_HIGH; // RQ11
                    pcount  <= 32'h0000_0000;
                    PIN_IRQ <= 1'b1;
                end
                ofef_pkg::PL_HIGH:
                begin
                    if (pcount >= 32'(PULSE_ON_CYC - 1))
                    begin
                        pstate  <= ofef_pkg::PL_LOW;
                        pcount  <= 32'h0000_0000;
                        PIN_IRQ <= 1'b0;
                    end
                    else
                        pcount <= pcount + 32'h0000_0001;
                end
                ofef_pkg::PL_LOW:
                begin
                    if (pcount >= 32'(PULSE_OFF_CYC - 1))
                    begin
                        pstate  <= ofef_pkg::PL_HIGH;
                        pcount  <= 32'h0000_0000;
                        PIN_IRQ <= 1'b1;
                    end
                    else
                        pcount <= pcount + 32'h0000_0001;
                end
                default:
                begin
                    pstate  <= ofef_pkg::PL_IDLE;
                    pcount  <= 32'h0000_0000;
                    PIN_IRQ <= 1'b0;
                end
            endcase
        end
    end

    chk_status_reserved: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ3
        RD_STB && hit(ADDR, `OFEF_OFS_SC_STATUS) |=> (RDATA & 8'h17) == 8'h00)
        else $error("reserved status bits not zero");
    chk_status_short: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ1
        RD_STB && hit(ADDR, `OFEF_OFS_SC_STATUS) |=> RDATA[7:5] == $past(src[7:5]))
        else $error("status short bits wrong");
    chk_status_power: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ2
        RD_STB && hit(ADDR, `OFEF_OFS_SC_STATUS) |=> RDATA[3] == $past(src.com_pwr))
        else $error("common power bit wrong");
    chk_latch_short: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ4
        src.sc_left |=> latched[7])
        else $error("left short not latched");
    chk_latch_headset: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ5
        $changed(src.headset) |=> latched[2])
        else $error("headset change not latched");
    chk_latch_button: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ6
        $rose(src.button) |=> latched[3] && button_sticky)
        else $error("button press not latched");
    chk_latch_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ7
        src.gate_left && src.gate_right |=> latched[1:0] == 2'b11)
        else $error("noise gate not latched");
    chk_live_mirror: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ8
        RD_STB && hit(ADDR, `OFEF_OFS_LIVE) |=> RDATA[2] == $past(src.headset)
        && RDATA[7:5] == $past(src[7:5]))
        else $error("live register mismatch");
    chk_live_sticky: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ10
        button_sticky && !rd_btn_clr |=> button_sticky)
        else $error("live button bit dropped early");
    chk_latch_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ12
        latched[6] && !rd_latched |=> latched[6])
        else $error("latched flag lost");
    chk_repeat_stop: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RQ11
        rd_latched |=> !PIN_IRQ)
        else $error("pulses continue after read");

    cov_short_read: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        latched[7] ##1 rd_latched);
    cov_repeat_pulse: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(PIN_IRQ));
    cov_button_clear: cover property (@(posedge CLOCK) disable iff (!RESET_N)
        button_sticky && rd_btn_clr);
endmodule

/* tb/ofef_host.sv */
// Purpose: host model driving the register read/write strobes of the flag block
// Assumes: strobes are one-cycle pulses, read answer one cycle after the strobe
// Notes:   tasks are called hierarchically from tb
`timescale 1ns/1ns
`include "ofef_cfg.svh"
module ofef_host (
    input  wire logic                    clock,  // system clock
    input  wire logic [7:0]              rdata,  // read data
    input  wire logic                    rvalid, // read data valid
    output logic                         rd_stb, // read strobe
    output logic                         wr_stb, // write strobe
    output logic      [`OFEF_ADDR_W-1:0] addr,   // register offset
    output logic      [7:0]              wdata   // write data
);
    initial
    begin
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        addr = '0;
        wdata = 8'h00;
    end

    // answer is taken at the edge after the strobe edge
    task automatic rd(input logic [`OFEF_ADDR_W-1:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        #5;
        addr = a;
        rd_stb = 1'b1;
        @(posedge clock);
        #1;
        v = rvalid;
        d = rdata;
        #4;
        rd_stb = 1'b0;
    endtask

    // a whole byte is written to any offset, read-only latched register included; status is never written
    task automatic wr(input logic [`OFEF_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        #5;
        addr = a;
        wdata = d;
        wr_stb = 1'b1;
        @(posedge clock);
        #5;
        wr_stb = 1'b0;
    endtask
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench for the fault/event flag block
// Assumes: pulse counts shortened to 4 cycles
// Notes:   sources stepped one bit at a time through the struct
`timescale 1ns/1ns
`include "ofef_cfg.svh"
module tb;
    logic                    clock;
    logic                    reset_n;
    ofef_pkg::ofef_src_t     src;
    logic                    rd_stb;
    logic                    wr_stb;
    logic [`OFEF_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    pin_irq;
    logic                    seen;
    int                      n_fail = 0;
    int                      check_count = 0;

    ofef_flags #(.PULSE_ON_CYC(4), .PULSE_OFF_CYC(4)) dut_u (
        .CLOCK(clock), .RESET_N(reset_n), .SC_LEFT(src.sc_left), .SC_RIGHT(src.sc_right),
        .SC_COMMON(src.sc_common), .COM_PWR_UP(src.com_pwr), .BUTTON(src.button),
        .HEADSET(src.headset), .GATE_LEFT(src.gate_left), .GATE_RIGHT(src.gate_right),
        .RD_STB(rd_stb), .WR_STB(wr_stb), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
        .RVALID(rvalid), .PIN_IRQ(pin_irq));

    ofef_host host_u (.clock(clock), .rdata(rdata), .rvalid(rvalid), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .addr(addr), .wdata(wdata));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [`OFEF_ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] rd_d;
        logic       rd_v;
        host_u.rd(a, rd_d, rd_v);
        cmp({7'h00, rd_v}, 8'h01);
        cmp(rd_d, exp);
    endtask

    task automatic setsrc(input logic [7:0] val);
        @(posedge clock);
        #5;
        src = ofef_pkg::ofef_src_t'(val);
    endtask

    task automatic watch(input int n, output logic hit);
        hit = 1'b0;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            // an unknown level sticks as x so no compare can pass it
            if (pin_irq !== 1'b0 && hit !== 1'bx)
                hit = pin_irq;
        end
    endtask

    // status image: driver shorts in place, common power at bit 3
    function automatic logic [7:0] st_exp(input int i);
        return (i == 4) ? 8'h08 : ((i >= 5) ? (8'h01 << i) : 8'h00);
    endfunction

    // flag image: every source but common power in place
    function automatic logic [7:0] lv_exp(input int i);
        return (i == 4) ? 8'h00 : (8'h01 << i);
    endfunction

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        conclude();
    end

    initial
    begin
        reset_n = 1'b0;
        src = '0;
        repeat (10) @(posedge clock);
        #5;
        reset_n = 1'b1;
        rdchk(`OFEF_OFS_SC_STATUS, `OFEF_RST_REG);
        rdchk(`OFEF_OFS_LATCHED, `OFEF_RST_REG);
        rdchk(`OFEF_OFS_LIVE, `OFEF_RST_REG);
        rdchk(7'h10, 8'h00);
        host_u.wr(`OFEF_OFS_LATCHED, 8'hFF);
        rdchk(`OFEF_OFS_LATCHED, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            setsrc(8'h01 << i);
            repeat (5) @(posedge clock);
            rdchk(`OFEF_OFS_SC_STATUS, st_exp(i));
            rdchk(`OFEF_OFS_LIVE, lv_exp(i));
            rdchk(`OFEF_OFS_LATCHED, lv_exp(i));
            setsrc(8'h00);
            repeat (5) @(posedge clock);
            rdchk(`OFEF_OFS_SC_STATUS, 8'h00);
            rdchk(`OFEF_OFS_LIVE, (i == 3) ? 8'h08 : 8'h00);
            rdchk(`OFEF_OFS_LATCHED, (i == 3) ? 8'h00 : lv_exp(i));
            rdchk(`OFEF_OFS_LATCHED, 8'h00);
            rdchk(`OFEF_OFS_BTN_CLR, 8'h00);
            rdchk(`OFEF_OFS_LIVE, 8'h00);
        end
        // repeat mode: pulses until the latched register is read
        host_u.wr(`OFEF_OFS_PIN_CTRL, 8'h04);
        setsrc(8'h04);
        watch(40, seen);
        cmp({7'h00, seen}, 8'h01);
        rdchk(`OFEF_OFS_LATCHED, 8'h04);
        repeat (2) @(posedge clock);
        watch(20, seen);
        cmp({7'h00, seen}, 8'h00);
        host_u.wr(`OFEF_OFS_PIN_CTRL, 8'h00);
        setsrc(8'h00);
        watch(20, seen);
        cmp({7'h00, seen}, 8'h00);
        rdchk(`OFEF_OFS_LATCHED, 8'h04);
        conclude();
    end
endmodule
